// ### zq_cal_seq.sv
// Our own choices: the Wishbone slave port and the address map.
module zq_cal_seq #(
	parameter int unsigned CAL_CYC = zq_pkg::CAL_DURATION_CYC,
	parameter int unsigned POLL_CYC = zq_pkg::TEMP_UPDATE_CYC
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic [3:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	input wire logic i_wb_we,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_dq_busy,
	input wire logic i_term_write,
	input wire logic i_temp_read,
	output logic o_multipurpose_command,
	output logic o_impedance_cal_start,
	output logic o_impedance_cal_latch,
	output logic o_mode_write,
	output logic [7:0] o_mode_addr,
	output logic [7:0] o_mode_data,
	output logic [1:0] o_cs,
	output logic o_deselect,
	output logic o_temp_poll_due
);
	typedef enum logic [3:0] {
		S_IDLE = 4'b0001,
		S_ISSUE = 4'b0010,
		S_LATCH_WAIT = 4'b0100,
		S_RESET_WAIT = 4'b1000
	} seq_t;
	typedef struct packed {
		seq_t fsm;
		logic [31:0] wb_dat;
		logic wb_ack;
		logic [1:0] cmd;
		logic rank;
		logic pd;
		logic refused;
		logic need_cal;
		logic cal_rank;
		logic [zq_pkg::MODE_W-1:0] mode;
		logic [zq_pkg::MODE_W-1:0] pend_mode;
		logic [31:0] poll_iv;
		logic multipurpose_command;
		logic start;
		logic latch;
		logic mrw;
		logic [7:0] maddr;
		logic [7:0] mdata;
		logic [1:0] cs;
		logic desel;
		logic due;
	} seq_state_t;
	seq_state_t state, next_state;
	logic cal_busy, lat_busy, rst_busy, term_busy;
	logic ld_cal, ld_lat, ld_rst, poll_due;
	logic wr_ctrl, wr_mode, wr_poll, go, block;
	always_comb begin
		wr_ctrl = i_wb_cyc && i_wb_stb && i_wb_we && !state.wb_ack && i_wb_sel[0] &&
			(i_wb_adr == zq_pkg::REG_CTRL);
		wr_mode = i_wb_cyc && i_wb_stb && i_wb_we && !state.wb_ack &&
			(i_wb_adr == zq_pkg::REG_MODE);
		wr_poll = i_wb_cyc && i_wb_stb && i_wb_we && !state.wb_ack &&
			(i_wb_adr == zq_pkg::REG_POLL);
		go = wr_ctrl && i_wb_dat[zq_pkg::CTRL_GO];
		// calibration time does not block orders
		block = (state.fsm != S_IDLE) || lat_busy || rst_busy;
		ld_cal = 1'b0;
		ld_lat = 1'b0;
		ld_rst = 1'b0;
		next_state = state;
		next_state.wb_ack = i_wb_cyc && i_wb_stb && !state.wb_ack;
		next_state.multipurpose_command = 1'b0;
		next_state.start = 1'b0;
		next_state.latch = 1'b0;
		next_state.mrw = 1'b0;
		next_state.due = poll_due;
		next_state.wb_dat = '0;
		case (i_wb_adr)
			zq_pkg::REG_CTRL: next_state.wb_dat[4:0] = {state.pd, state.rank, state.cmd, 1'b0};
			zq_pkg::REG_STATUS: begin
				next_state.wb_dat[zq_pkg::ST_BUSY] = block;
				next_state.wb_dat[zq_pkg::ST_CAL_RUN] = cal_busy;
				next_state.wb_dat[zq_pkg::ST_DESEL] = state.desel;
				next_state.wb_dat[zq_pkg::ST_RST_WAIT] = rst_busy;
				next_state.wb_dat[zq_pkg::ST_REFUSED] = state.refused;
				next_state.wb_dat[zq_pkg::ST_NEED_CAL] = state.need_cal;
				next_state.wb_dat[zq_pkg::ST_POLL_DUE] = state.due;
				next_state.wb_dat[zq_pkg::ST_RANK] = state.cal_rank;
			end
			zq_pkg::REG_MODE: next_state.wb_dat[zq_pkg::MODE_W-1:0] = state.mode;
			zq_pkg::REG_POLL: next_state.wb_dat = state.poll_iv;
			default: next_state.wb_dat = '0;
		endcase
		if (wr_ctrl) begin
			next_state.cmd = i_wb_dat[zq_pkg::CTRL_CMD_LO +: 2];
			next_state.rank = i_wb_dat[zq_pkg::CTRL_RANK];
			next_state.pd = i_wb_dat[zq_pkg::CTRL_PD];
			if (go) begin
				next_state.refused = 1'b0;
			end
		end
		if (wr_mode) begin
			next_state.pend_mode = i_wb_dat[zq_pkg::MODE_W-1:0];
		end
		if (wr_poll) begin
			next_state.poll_iv = i_wb_dat;
		end
		case (state.fsm)
			S_IDLE: begin
				if (go) begin
					next_state.fsm = S_ISSUE;
				end
			end
			S_ISSUE: begin
				next_state.fsm = S_IDLE;
				case (state.cmd)
					zq_pkg::CMD_START: begin
						if (state.pd || cal_busy) begin
							next_state.refused = 1'b1;
						end else begin
							next_state.multipurpose_command = 1'b1;
							next_state.start = 1'b1;
							next_state.cs = 2'b01 << state.rank;
							next_state.cal_rank = state.rank;
							ld_cal = 1'b1;
						end
					end
					zq_pkg::CMD_LATCH: begin
						if (state.pd || cal_busy || i_dq_busy || term_busy) begin
							next_state.refused = 1'b1;
						end else begin
							next_state.multipurpose_command = 1'b1;
							next_state.latch = 1'b1;
							next_state.cs = 2'b01 << state.cal_rank;
							next_state.need_cal = 1'b0;
							ld_lat = 1'b1;
							next_state.fsm = S_LATCH_WAIT;
						end
					end
					zq_pkg::CMD_RESET: begin
						next_state.mrw = 1'b1;
						next_state.maddr = zq_pkg::IMP_CTRL_ADDR;
						next_state.mdata = zq_pkg::IMP_RESET_VAL;
						next_state.cs = 2'b01 << state.rank;
						ld_rst = 1'b1;
						next_state.fsm = S_RESET_WAIT;
					end
					default: begin
						if (cal_busy) begin
							next_state.refused = 1'b1;
						end else begin
							next_state.mrw = 1'b1;
							next_state.maddr = zq_pkg::IO_MODE_ADDR;
							next_state.mdata = state.pend_mode[7:0];
							next_state.cs = 2'b01 << state.rank;
							next_state.mode = state.pend_mode;
							// only pull-up point change needs recalibration
							if (state.pend_mode[zq_pkg::MODE_PU] != state.mode[zq_pkg::MODE_PU]) begin
								next_state.need_cal = 1'b1;
							end
						end
					end
				endcase
			end
			S_LATCH_WAIT: begin
				next_state.desel = 1'b1;
				if (!lat_busy) begin
					next_state.desel = 1'b0;
					next_state.fsm = S_IDLE;
				end
			end
			S_RESET_WAIT: begin
				if (!rst_busy) begin
					next_state.fsm = S_IDLE;
				end
			end
			default: next_state.fsm = S_IDLE;
		endcase
	end
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			state <= '0;
			state.fsm <= S_IDLE;
			state.poll_iv <= POLL_CYC;
		end else begin
			state <= next_state;
		end
	end
	zq_timer #(.W(16)) u_cal (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_load(ld_cal),
		.i_count(16'(CAL_CYC)),
		.o_busy(cal_busy)
	);
	zq_timer #(.W(8)) u_lat (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_load(ld_lat),
		.i_count(8'(zq_pkg::CAL_LATCH_CYC)),
		.o_busy(lat_busy)
	);
	zq_timer #(.W(8)) u_rst (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_load(ld_rst),
		.i_count(8'(zq_pkg::CAL_RESET_CYC)),
		.o_busy(rst_busy)
	);
	zq_timer #(.W(8)) u_term (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_load(i_term_write),
		.i_count(8'(zq_pkg::TERM_OFF_CYC)),
		.o_busy(term_busy)
	);
	zq_poll_timer #(.W(32)) u_poll (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_interval(state.poll_iv),
		.i_polled(i_temp_read),
		.o_due(poll_due)
	);
	assign o_wb_dat = state.wb_dat;
	assign o_wb_ack = state.wb_ack;
	assign o_multipurpose_command = state.multipurpose_command;
	assign o_impedance_cal_start = state.start;
	assign o_impedance_cal_latch = state.latch;
	assign o_mode_write = state.mrw;
	assign o_mode_addr = state.maddr;
	assign o_mode_data = state.mdata;
	assign o_cs = state.cs;
	assign o_deselect = state.desel;
	assign o_temp_poll_due = state.due;

	property p_latch_after_cal;
		@(posedge i_mclk) disable iff (i_rst)
		state.latch |-> !$past(cal_busy) && !$past(state.pd);
	endproperty
	a_latch_after_cal: assert property (p_latch_after_cal) else $error("latch too early");
	property p_start_not_pd;
		@(posedge i_mclk) disable iff (i_rst)
		state.start |-> !$past(state.pd);
	endproperty
	a_start_not_pd: assert property (p_start_not_pd) else $error("start in power-down");
	sequence s_latch;
		state.latch;
	endsequence
	sequence s_desel_hold;
		##1 state.desel [*7];
	endsequence
	property p_desel_after_latch;
		@(posedge i_mclk) disable iff (i_rst)
		s_latch |-> s_desel_hold;
	endproperty
	a_desel_after_latch: assert property (p_desel_after_latch) else $error("deselect short");
	property p_no_cmd_in_desel;
		@(posedge i_mclk) disable iff (i_rst)
		state.desel |-> !state.multipurpose_command && !state.mrw;
	endproperty
	a_no_cmd_in_desel: assert property (p_no_cmd_in_desel) else $error("command in deselect");
	property p_mode_frozen;
		@(posedge i_mclk) disable iff (i_rst)
		(state.mrw && state.maddr == zq_pkg::IO_MODE_ADDR) |-> !$past(cal_busy);
	endproperty
	a_mode_frozen: assert property (p_mode_frozen) else $error("io field during calibration");
	property p_reset_wait;
		@(posedge i_mclk) disable iff (i_rst)
		(state.mrw && state.maddr == zq_pkg::IMP_CTRL_ADDR) |-> ##1 block [*3];
	endproperty
	a_reset_wait: assert property (p_reset_wait) else $error("reset wait short");
	property p_no_overlap;
		@(posedge i_mclk) disable iff (i_rst)
		state.start |-> !$past(cal_busy);
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("calibrations overlap");
	property p_term_off;
		@(posedge i_mclk) disable iff (i_rst)
		state.latch |-> !$past(term_busy) && !$past(i_dq_busy);
	endproperty
	a_term_off: assert property (p_term_off) else $error("latch with bus busy");
	property p_pu_recal;
		@(posedge i_mclk) disable iff (i_rst)
		(state.mrw && state.maddr == zq_pkg::IO_MODE_ADDR &&
			$past(state.pend_mode[zq_pkg::MODE_PU]) != $past(state.mode[zq_pkg::MODE_PU]))
			|-> state.need_cal;
	endproperty
	a_pu_recal: assert property (p_pu_recal) else $error("recal flag missing");
endmodule : zq_cal_seq

// ### zq_pkg.sv
// Behaviour
// - poll temperature status often enough that gradient times total delay stays within 2C
// - calibration start may be issued any time except during power-down
// - latch only outside power-down, after 1 us calibration time, data bus idle
// - after latch keep command bus deselected for max(30 ns, 8 clocks)
// - no impedance-related mode field change between start and calibration time end
// - any valid commands may be issued during the calibration time
// - let a terminated write turn termination off before latching
// - ranks sharing a resistor never overlap their calibration periods
// - termination value may change after calibration without recalibrating
// - pull-up point change requires a new calibration
package zq_pkg;
	localparam int unsigned CLK_MHZ = 125;
	localparam int unsigned CK_MHZ = 125;
	localparam int unsigned CAL_DURATION_US = 1;
	localparam int unsigned CAL_LATCH_NS = 30;
	localparam int unsigned CAL_LATCH_NCK = 8;
	localparam int unsigned CAL_RESET_NS = 50;
	localparam int unsigned CAL_RESET_NCK = 3;
	localparam int unsigned TEMP_UPDATE_MS = 32;
	localparam int unsigned TEMP_MARGIN_C = 2;
	localparam int unsigned TERM_OFF_CYC = 16;
	localparam int unsigned CAL_DURATION_CYC = CAL_DURATION_US * CLK_MHZ;
	localparam int unsigned LATCH_NS_CYC = (CAL_LATCH_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned RESET_NS_CYC = (CAL_RESET_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned LATCH_CK_CYC = (CAL_LATCH_NCK * CLK_MHZ + CK_MHZ - 1) / CK_MHZ;
	localparam int unsigned RESET_CK_CYC = (CAL_RESET_NCK * CLK_MHZ + CK_MHZ - 1) / CK_MHZ;
	localparam int unsigned CAL_LATCH_CYC = (LATCH_NS_CYC > LATCH_CK_CYC) ?
		LATCH_NS_CYC : LATCH_CK_CYC;
	localparam int unsigned CAL_RESET_CYC = (RESET_NS_CYC > RESET_CK_CYC) ?
		RESET_NS_CYC : RESET_CK_CYC;
	localparam int unsigned TEMP_UPDATE_CYC = TEMP_UPDATE_MS * CLK_MHZ * 1000;
	// command codes on the controller's command port
	localparam logic [1:0] CMD_START = 2'h0;
	localparam logic [1:0] CMD_LATCH = 2'h1;
	localparam logic [1:0] CMD_RESET = 2'h2;
	localparam logic [1:0] CMD_MODE = 2'h3;
	// register offsets (byte addresses)
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_MODE = 4'h8;
	localparam logic [3:0] REG_POLL = 4'hC;
	// control register fields
	localparam int unsigned CTRL_GO = 0;
	localparam int unsigned CTRL_CMD_LO = 1;
	localparam int unsigned CTRL_RANK = 3;
	localparam int unsigned CTRL_PD = 4;
	// status register fields
	localparam int unsigned ST_BUSY = 0;
	localparam int unsigned ST_CAL_RUN = 1;
	localparam int unsigned ST_DESEL = 2;
	localparam int unsigned ST_RST_WAIT = 3;
	localparam int unsigned ST_REFUSED = 4;
	localparam int unsigned ST_NEED_CAL = 5;
	localparam int unsigned ST_POLL_DUE = 6;
	localparam int unsigned ST_RANK = 7;
	// mode register layout: pull-up point, pull-down strength, dq term, ca term
	localparam int unsigned MODE_PU = 0;
	localparam int unsigned MODE_PULLDOWN_DRIVE_STRENGTH_LO = 1;
	localparam int unsigned MODE_DQ_LO = 4;
	localparam int unsigned MODE_CA_LO = 7;
	localparam int unsigned MODE_W = 10;
	localparam logic [7:0] IMP_CTRL_ADDR = 8'h0A;
	localparam logic [7:0] IMP_RESET_VAL = 8'h01;
	localparam logic [7:0] IO_MODE_ADDR = 8'h0B;
endpackage : zq_pkg

// ### zq_timer.sv
module zq_timer #(
	parameter int unsigned W = 16
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_load,
	input wire logic [W-1:0] i_count,
	output logic o_busy
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} timer_state_t;
	timer_state_t state, next_state;
	always_comb begin
		next_state = state;
		if (i_load) begin
			next_state.cnt = i_count;
		end else if (state.cnt != '0) begin
			next_state.cnt = state.cnt - 1'b1;
		end
	end
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
	assign o_busy = (state.cnt != '0);
endmodule : zq_timer

// ### zq_poll_timer.sv
module zq_poll_timer #(
	parameter int unsigned W = 32
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_interval,
	input wire logic i_polled,
	output logic o_due
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic due;
	} poll_state_t;
	poll_state_t state, next_state;
	always_comb begin
		next_state = state;
		if (state.cnt >= i_interval) begin
			next_state.due = 1'b1;
		end else begin
			next_state.cnt = state.cnt + 1'b1;
		end
		// a new due wins over the clear that lands with it
		if (i_polled) begin
			next_state.cnt = '0;
			next_state.due = (state.cnt >= i_interval) && !state.due;
		end
	end
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
	assign o_due = state.due;
endmodule : zq_poll_timer

// ### zq_dev_model.sv
module zq_dev_model #(
	parameter int CAL_CYC = 20,
	parameter int TSI_CYC = 200
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_mpc,
	input wire logic i_start,
	input wire logic i_latch,
	input wire logic i_mode_write,
	input wire logic [7:0] i_mode_addr,
	input wire logic [7:0] i_mode_data,
	input wire logic i_dq_busy,
	output int o_faults
);
	timeunit 1ns;
	timeprecision 1ps;
	int cal_left;
	int desel_left;
	int temp_age;
	logic calibrated;
	logic [7:0] temp_status;
	logic cmd;
	assign cmd = i_start | i_latch | i_mode_write;
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cal_left = 0;
			desel_left = 0;
			temp_age = 0;
			calibrated = 1'b0;
			temp_status = 8'h00;
			o_faults = 0;
		end else begin
			temp_age = (temp_age + 1) % TSI_CYC;
			if (temp_age == 0) temp_status = temp_status + 8'h01;
			if (desel_left > 0 && cmd) o_faults++;
			if (desel_left > 0) desel_left--;
			if (i_latch && (cal_left > 1 || i_dq_busy || !i_mpc)) o_faults++;
			if (i_mode_write && i_mode_addr == zq_pkg::IO_MODE_ADDR && cal_left > 0) o_faults++;
			if (i_start && i_mpc) cal_left = CAL_CYC;
			else if (cal_left > 0) cal_left--;
			if (i_latch) begin
				calibrated = 1'b1;
				desel_left = zq_pkg::CAL_LATCH_CYC;
			end
			if (i_mode_write && i_mode_addr == zq_pkg::IMP_CTRL_ADDR && i_mode_data[0]) calibrated = 1'b0;
		end
	end
endmodule : zq_dev_model

// ### tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// calibration long enough that the early latch and mode orders land inside it
	localparam int CAL = 60;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic [3:0] i_wb_adr = 4'h0;
	logic [31:0] i_wb_dat = 32'h0;
	logic [3:0] i_wb_sel = 4'h0;
	logic i_wb_we = 1'b0;
	logic i_wb_cyc = 1'b0;
	logic i_wb_stb = 1'b0;
	logic i_dq_busy = 1'b0;
	logic i_term_write = 1'b0;
	logic i_temp_read = 1'b0;
	logic [31:0] o_wb_dat;
	logic o_wb_ack, o_multipurpose_command, o_impedance_cal_start, o_impedance_cal_latch;
	logic o_mode_write, o_deselect, o_temp_poll_due;
	logic [7:0] o_mode_addr, o_mode_data;
	logic [1:0] o_cs;
	int dev_faults;
	int num_errors = 0;
	int comparisons = 0;
	int dlen = 0;
	logic [31:0] exp_q[$];
	logic [31:0] seen, pend, rd;
	always #4 i_mclk = ~i_mclk;
	zq_cal_seq #(.CAL_CYC(CAL), .POLL_CYC(200)) u_zq_cal_seq (.i_mclk(i_mclk), .i_rst(i_rst),
		.i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel), .i_wb_we(i_wb_we),
		.i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
		.i_dq_busy(i_dq_busy), .i_term_write(i_term_write), .i_temp_read(i_temp_read),
		.o_multipurpose_command(o_multipurpose_command),
		.o_impedance_cal_start(o_impedance_cal_start), .o_impedance_cal_latch(o_impedance_cal_latch),
		.o_mode_write(o_mode_write), .o_mode_addr(o_mode_addr), .o_mode_data(o_mode_data),
		.o_cs(o_cs), .o_deselect(o_deselect), .o_temp_poll_due(o_temp_poll_due));
	zq_dev_model #(.CAL_CYC(CAL), .TSI_CYC(200)) u_zq_dev_model (.i_mclk(i_mclk), .i_rst(i_rst),
		.i_mpc(o_multipurpose_command), .i_start(o_impedance_cal_start),
		.i_latch(o_impedance_cal_latch), .i_mode_write(o_mode_write), .i_mode_addr(o_mode_addr),
		.i_mode_data(o_mode_data), .i_dq_busy(i_dq_busy), .o_faults(dev_faults));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk
	task automatic test_done();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : test_done
	task automatic wb(input logic [3:0] a, input logic we, input logic [31:0] d);
		int n;
		@(posedge i_mclk);
		i_wb_adr <= a;
		i_wb_we <= we;
		i_wb_dat <= d;
		i_wb_sel <= 4'hF;
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		n = 0;
		do begin
			@(posedge i_mclk);
			n++;
		end while (o_wb_ack !== 1'b1 && n < 50);
		if (n >= 50) num_errors++;
		rd = o_wb_dat;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
		i_wb_we <= 1'b0;
	endtask : wb
	task automatic rdc(input string what, input logic [3:0] a, input logic [31:0] m,
		input logic [31:0] e);
		wb(a, 1'b0, 32'h0);
		chk(what, e, rd & m);
	endtask : rdc
	task automatic go(input logic [1:0] cmd, input logic rank, input logic pd);
		wb(zq_pkg::REG_CTRL, 1'b1, {27'h0, pd, rank, cmd, 1'b1});
		repeat (4) @(posedge i_mclk);
	endtask : go
	always @(posedge i_mclk) begin
		if (!i_rst && (o_impedance_cal_start || o_impedance_cal_latch || o_mode_write)) begin
			seen = o_mode_write ? {10'h0, 4'h1, 2'h0, o_mode_addr, o_mode_data} :
				{10'h0, o_multipurpose_command, o_impedance_cal_start, o_impedance_cal_latch,
				1'b0, o_cs, 16'h0};
			chk("command", (exp_q.size() > 0) ? exp_q.pop_front() : 32'hFFFFFFFF, seen);
		end
		if (!i_rst && o_deselect) dlen++;
		else if (dlen != 0) begin
			chk("deselect_len", zq_pkg::CAL_LATCH_CYC, dlen);
			dlen = 0;
		end
	end
	initial begin
		repeat (20000) @(posedge i_mclk);
		num_errors++;
		test_done();
	end
	initial begin
		void'($urandom(32'h914a));
		repeat (16) @(posedge i_mclk);
		i_rst <= 1'b0;
		rdc("status", zq_pkg::REG_STATUS, 32'h1F, 32'h0);
		rdc("unmapped", 4'h6, 32'hFFFFFFFF, 32'h0);
		rdc("poll", zq_pkg::REG_POLL, 32'hFFFFFFFF, 32'd200);
		go(zq_pkg::CMD_START, 1'b0, 1'b1);
		rdc("status", zq_pkg::REG_STATUS, 32'h12, 32'h10);
		exp_q.push_back({10'h0, 4'hC, 2'h1, 16'h0});
		go(zq_pkg::CMD_START, 1'b0, 1'b0);
		rdc("status", zq_pkg::REG_STATUS, 32'h12, 32'h02);
		go(zq_pkg::CMD_START, 1'b1, 1'b0);
		rdc("status", zq_pkg::REG_STATUS, 32'h10, 32'h10);
		go(zq_pkg::CMD_MODE, 1'b0, 1'b0);
		rdc("status", zq_pkg::REG_STATUS, 32'h10, 32'h10);
		go(zq_pkg::CMD_LATCH, 1'b0, 1'b0);
		rdc("status", zq_pkg::REG_STATUS, 32'h10, 32'h10);
		repeat (CAL + 10) @(posedge i_mclk);
		rdc("status", zq_pkg::REG_STATUS, 32'h02, 32'h0);
		i_dq_busy <= 1'b1;
		go(zq_pkg::CMD_LATCH, 1'b0, 1'b0);
		i_dq_busy <= 1'b0;
		rdc("status", zq_pkg::REG_STATUS, 32'h10, 32'h10);
		i_term_write <= 1'b1;
		@(posedge i_mclk);
		i_term_write <= 1'b0;
		go(zq_pkg::CMD_LATCH, 1'b0, 1'b0);
		rdc("status", zq_pkg::REG_STATUS, 32'h10, 32'h10);
		repeat (20) @(posedge i_mclk);
		exp_q.push_back({10'h0, 4'hA, 2'h1, 16'h0});
		go(zq_pkg::CMD_LATCH, 1'b0, 1'b0);
		repeat (12) @(posedge i_mclk);
		pend = ($urandom() & 32'h3FF) | 32'h1;
		wb(zq_pkg::REG_MODE, 1'b1, pend);
		exp_q.push_back({10'h0, 4'h1, 2'h0, zq_pkg::IO_MODE_ADDR, pend[7:0]});
		go(zq_pkg::CMD_MODE, 1'b0, 1'b0);
		rdc("mode", zq_pkg::REG_MODE, 32'h3FF, pend);
		rdc("status", zq_pkg::REG_STATUS, 32'h30, 32'h20);
		exp_q.push_back({10'h0, 4'h1, 2'h0, zq_pkg::IMP_CTRL_ADDR, zq_pkg::IMP_RESET_VAL});
		go(zq_pkg::CMD_RESET, 1'b0, 1'b0);
		repeat (6) @(posedge i_mclk);
		exp_q.push_back({10'h0, 4'hC, 2'h2, 16'h0});
		go(zq_pkg::CMD_START, 1'b1, 1'b0);
		repeat (CAL + 10) @(posedge i_mclk);
		exp_q.push_back({10'h0, 4'hA, 2'h2, 16'h0});
		go(zq_pkg::CMD_LATCH, 1'b1, 1'b0);
		repeat (12) @(posedge i_mclk);
		// termination fields change, pull-up point kept: no new calibration wanted
		pend = pend ^ 32'h3F0;
		wb(zq_pkg::REG_MODE, 1'b1, pend);
		exp_q.push_back({10'h0, 4'h1, 2'h0, zq_pkg::IO_MODE_ADDR, pend[7:0]});
		go(zq_pkg::CMD_MODE, 1'b1, 1'b0);
		rdc("mode", zq_pkg::REG_MODE, 32'h3FF, pend);
		rdc("status", zq_pkg::REG_STATUS, 32'hA0, 32'h80);
		wb(zq_pkg::REG_POLL, 1'b1, 32'd64);
		i_temp_read <= 1'b1;
		@(posedge i_mclk);
		i_temp_read <= 1'b0;
		repeat (3) @(posedge i_mclk);
		chk("poll_due", 32'h0, {31'h0, o_temp_poll_due});
		repeat (70) @(posedge i_mclk);
		chk("poll_due", 32'h1, {31'h0, o_temp_poll_due});
		rdc("status", zq_pkg::REG_STATUS, 32'h40, 32'h40);
		chk("queue", 32'h0, exp_q.size());
		chk("device_faults", 32'h0, dev_faults);
		test_done();
	end
endmodule : tb_top
